//--- inc/pcs_tx_regs.vh
// Constants for the transmit stuffing and error-delimiter block
`ifndef PCS_TX_REGS_VH
`define PCS_TX_REGS_VH

// Ternary symbol encodings, two's complement in two bits
`define TERN_ZERO       2'h0
`define TERN_POS        2'h1
`define TERN_NEG        2'h3

// Widths of the data path
`define NIB_W           4
`define GRP_W           3
`define ACC_W           6
`define CNT_W           3

// Number of start-delimiter pairs sent before data
`define SSD_PAIRS       2'h3

// Buffer entry layout: {end marker, error, nibble}
`define ENT_W           6
`define ENT_END_BIT     5
`define ENT_ERR_BIT     4

// Kind of the pair on the output, for the symbol tag port
`define KIND_W          3
`define KIND_IDLE       3'h0
`define KIND_SSD        3'h1
`define KIND_DATA       3'h2
`define KIND_ESD1       3'h3
`define KIND_ERR_ESD1   3'h4
`define KIND_ESD2       3'h5
`define KIND_ESD3       3'h6
`define KIND_ERR_ESD3   3'h7

`endif

//--- verilog/tern_map.v
// Maps a 3-bit data group onto a ternary pair
`timescale 1ns/100ps
`default_nettype none
`include "pcs_tx_regs.vh"

module tern_map (
    // Group in
    input  wire [2:0] grp,
    // Ternary pair out
    output reg  [1:0] tern_a,
    output reg  [1:0] tern_b
);

    // Eight groups onto the eight non-(0,0) pairs, so data never mimics a delimiter zero
    always @* begin
        case (grp)
            3'h0: begin
                tern_a = `TERN_NEG;
                tern_b = `TERN_NEG;
            end
            3'h1: begin
                tern_a = `TERN_NEG;
                tern_b = `TERN_ZERO;
            end
            3'h2: begin
                tern_a = `TERN_NEG;
                tern_b = `TERN_POS;
            end
            3'h3: begin
                tern_a = `TERN_ZERO;
                tern_b = `TERN_NEG;
            end
            3'h4: begin
                tern_a = `TERN_ZERO;
                tern_b = `TERN_POS;
            end
            3'h5: begin
                tern_a = `TERN_POS;
                tern_b = `TERN_NEG;
            end
            3'h6: begin
                tern_a = `TERN_POS;
                tern_b = `TERN_ZERO;
            end
            default: begin
                tern_a = `TERN_POS;
                tern_b = `TERN_POS;
            end
        endcase
    end

endmodule
`default_nettype wire

//--- verilog/fifo2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module fifo2 #(
    parameter W = 6
) (
    // Clock, reset, enable
    input  wire         ref_clk,
    input  wire         rst,
    input  wire         clk_en,
    // Fill side
    input  wire         in_valid,
    output reg          in_ready,
    input  wire [W-1:0] in_data,
    // Drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);

    reg [W-1:0] mem_q [0:1];
    reg         wr_q;
    reg         rd_q;
    reg [1:0]   cnt_q;
    wire        push;
    wire        pop;
    reg [1:0]   cnt_d;

    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_q];

    // Next fill level
    always @* begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    // Pointers, level and registered ready
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            cnt_q    <= 2'h0;
            in_ready <= 1'b0;
        end else if (clk_en) begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d != 2'h2);
        end
    end

    // Storage, no reset needed
    always @(posedge ref_clk) begin
        if (clk_en && push) begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule
`default_nettype wire

//--- verilog/pcs_tx_stuff_and_error.v
// Transmit 4B/3B regrouping, stuffing and end-delimiter selection
`timescale 1ns/100ps
`default_nettype none
`include "pcs_tx_regs.vh"

module pcs_tx_stuff_and_error (
    // Clock, reset, enable
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       clk_en,
    // MII transmit side
    input  wire       tx_en,
    input  wire       tx_er,
    input  wire [3:0] txd,
    output wire       mii_ready,
    // Ternary pair side
    output reg  [1:0] pair_a,
    output reg  [1:0] pair_b,
    output reg  [2:0] pair_kind,
    output reg        pair_valid,
    input  wire       pair_ready,
    // Status
    output reg        tx_err_flag
);

    // Converter states
    localparam S_IDLE = 3'h0;
    localparam S_SSD  = 3'h1;
    localparam S_DATA = 3'h2;
    localparam S_ESD1 = 3'h3;
    localparam S_ESD2 = 3'h4;
    localparam S_ESD3 = 3'h5;

    // Input framing
    reg                  en_prev_q;
    reg                  end_pend_q;
    reg                  in_valid;
    reg  [`ENT_W-1:0]    in_data;
    wire                 fifo_ready;

    // Buffer head
    wire                 head_valid;
    wire [`ENT_W-1:0]    head;
    wire                 head_end;
    wire                 head_err;
    wire [`NIB_W-1:0]    head_nib;

    // Converter state
    reg  [2:0]           state_q;
    reg  [2:0]           state_d;
    reg  [1:0]           ssd_q;
    reg  [`ACC_W-1:0]    acc_q;
    reg  [`CNT_W-1:0]    cnt_q;
    reg                  er_pend_q;
    reg                  err_tail_q;

    // Data step results
    reg                  emit;
    reg                  pop;
    reg                  go_esd;
    reg  [`GRP_W-1:0]    grp;
    reg  [`ACC_W-1:0]    acc_d;
    reg  [`CNT_W-1:0]    cnt_d;
    reg  [`ACC_W-1:0]    comb;
    reg  [`CNT_W-1:0]    rem;

    // Output selection
    reg                  out_emit;
    reg  [1:0]           out_a;
    reg  [1:0]           out_b;
    reg  [2:0]           out_kind;
    wire [1:0]           map_a;
    wire [1:0]           map_b;
    wire                 advance;

    assign advance   = clk_en & (~pair_valid | pair_ready);
    assign mii_ready = fifo_ready;
    assign head_end  = head[`ENT_END_BIT];
    assign head_err  = head[`ENT_ERR_BIT];
    assign head_nib  = head[`NIB_W-1:0];

    // Entry to the buffer: nibble while enabled, one end marker after the fall
    always @* begin
        in_valid = 1'b0;
        in_data  = {`ENT_W{1'b0}};
        if (end_pend_q) begin
            in_valid = 1'b1;
            in_data  = {1'b1, 1'b0, 4'h0};
        end else if (tx_en) begin
            in_valid = 1'b1;
            in_data  = {1'b0, tx_er & tx_en, txd};
        end
    end

    // Track the fall of enable; the marker waits until the buffer takes it
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_prev_q  <= 1'b0;
            end_pend_q <= 1'b0;
        end else if (clk_en) begin
            en_prev_q <= tx_en;
            if (en_prev_q && !tx_en) begin
                end_pend_q <= 1'b1;
            end else if (end_pend_q && fifo_ready) begin
                end_pend_q <= 1'b0;
            end
        end
    end

    // Nibble buffer absorbs stalls from the pair side
    fifo2 #(
        .W(`ENT_W)
    ) u_buf (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .clk_en    (clk_en),
        .in_valid  (in_valid),
        .in_ready  (fifo_ready),
        .in_data   (in_data),
        .out_valid (head_valid),
        .out_ready (advance & pop),
        .out_data  (head)
    );

    // One regrouping step: emit a group, take a nibble, or stuff at the end
    always @* begin
        emit   = 1'b0;
        pop    = 1'b0;
        go_esd = 1'b0;
        grp    = 3'h0;
        acc_d  = acc_q;
        cnt_d  = cnt_q;
        comb   = {`ACC_W{1'b0}};
        rem    = 3'h0;
        if (state_q == S_DATA) begin
            if (cnt_q >= 3'h3) begin
                emit = 1'b1;
                grp  = acc_q[2:0];
                rem  = cnt_q - 3'h3;
                comb = acc_q >> 3;
                if (head_valid && !head_end && rem <= 3'h2) begin
                    pop  = 1'b1;
                    comb = comb | ({2'h0, head_nib} << rem);
                    rem  = rem + 3'h4;
                end
                acc_d = comb;
                cnt_d = rem;
            end else if (head_valid) begin
                pop = 1'b1;
                if (!head_end) begin
                    comb  = acc_q | ({2'h0, head_nib} << cnt_q);
                    emit  = 1'b1;
                    grp   = comb[2:0];
                    acc_d = comb >> 3;
                    cnt_d = cnt_q + 3'h1;
                end else begin
                    // Zero stuff bits fill the group; none when aligned
                    go_esd = 1'b1;
                    emit   = (cnt_q != 3'h0);
                    grp    = acc_q[2:0];
                    acc_d  = {`ACC_W{1'b0}};
                    cnt_d  = 3'h0;
                end
            end
        end
    end

    // Data group to ternary pair
    tern_map u_map (
        .grp    (grp),
        .tern_a (map_a),
        .tern_b (map_b)
    );

    // Next state and the pair to send
    always @* begin
        state_d  = state_q;
        out_emit = 1'b0;
        out_a    = `TERN_ZERO;
        out_b    = `TERN_ZERO;
        out_kind = `KIND_IDLE;
        case (state_q)
            S_IDLE: begin
                if (head_valid && !head_end) begin
                    state_d = S_SSD;
                end
            end
            S_SSD: begin
                out_emit = 1'b1;
                out_kind = `KIND_SSD;
                if (ssd_q == `SSD_PAIRS - 2'h1) begin
                    state_d = S_DATA;
                end
            end
            S_DATA: begin
                out_emit = emit;
                out_a    = map_a;
                out_b    = map_b;
                out_kind = `KIND_DATA;
                if (go_esd) begin
                    state_d = S_ESD1;
                end
            end
            S_ESD1: begin
                out_emit = 1'b1;
                out_kind = tx_err_flag ? `KIND_ERR_ESD1 : `KIND_ESD1;
                state_d  = S_ESD2;
            end
            S_ESD2: begin
                out_emit = 1'b1;
                out_kind = `KIND_ESD2;
                state_d  = S_ESD3;
            end
            S_ESD3: begin
                out_emit = 1'b1;
                if (err_tail_q) begin
                    out_a    = `TERN_NEG;
                    out_b    = `TERN_NEG;
                    out_kind = `KIND_ERR_ESD3;
                end else begin
                    out_a    = `TERN_POS;
                    out_b    = `TERN_POS;
                    out_kind = `KIND_ESD3;
                end
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // State, accumulator and start-delimiter count
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            ssd_q   <= 2'h0;
            acc_q   <= {`ACC_W{1'b0}};
            cnt_q   <= 3'h0;
        end else if (advance) begin
            state_q <= state_d;
            acc_q   <= acc_d;
            cnt_q   <= cnt_d;
            if (state_q == S_SSD) begin
                ssd_q <= ssd_q + 2'h1;
            end else begin
                ssd_q <= 2'h0;
            end
        end
    end

    // Error tracking: an error on a nibble that is followed by another nibble
    // raises the flag; an error on the last nibble only marks the tail.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            er_pend_q   <= 1'b0;
            err_tail_q  <= 1'b0;
            tx_err_flag <= 1'b0;
        end else if (advance) begin
            if (pop && !head_end) begin
                er_pend_q <= head_err;
                if (head_err) begin
                    err_tail_q <= 1'b1;
                end
                if (er_pend_q) begin
                    tx_err_flag <= 1'b1;
                end
            end else if (pop && head_end) begin
                er_pend_q <= 1'b0;
            end
            if (state_q == S_ESD1) begin
                tx_err_flag <= 1'b0;
            end
            if (state_q == S_ESD3) begin
                err_tail_q <= 1'b0;
            end
        end
    end

    // Registered pair output, held while the receiver stalls
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pair_a     <= `TERN_ZERO;
            pair_b     <= `TERN_ZERO;
            pair_kind  <= `KIND_IDLE;
            pair_valid <= 1'b0;
        end else if (advance) begin
            pair_valid <= out_emit;
            if (out_emit) begin
                pair_a    <= out_a;
                pair_b    <= out_b;
                pair_kind <= out_kind;
            end
        end
    end

endmodule
`default_nettype wire

//--- bench/pcs_tx_sva.sv
// Checker for the transmit stuffing and end-delimiter block
`timescale 1ns/100ps
`default_nettype none
`include "pcs_tx_regs.vh"

module pcs_tx_sva (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       clk_en,
    // MII side
    input wire logic       tx_en,
    input wire logic       tx_er,
    input wire logic [3:0] txd,
    input wire logic       mii_ready,
    // Pair side
    input wire logic [1:0] pair_a,
    input wire logic [1:0] pair_b,
    input wire logic [2:0] pair_kind,
    input wire logic       pair_valid,
    input wire logic       pair_ready,
    input wire logic       tx_err_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic       take;
    logic [2:0] last_q;
    logic [2:0] ssd_cnt_q;

    // Pair handed to the receiver on this edge
    assign take = clk_en && pair_valid && pair_ready;

    // Last kind handed over and run length of start pairs
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_q    <= `KIND_IDLE;
            ssd_cnt_q <= 3'h0;
        end else if (take) begin
            last_q    <= pair_kind;
            ssd_cnt_q <= (pair_kind == `KIND_SSD) ? ssd_cnt_q + 3'h1 : 3'h0;
        end
    end

    // Steps of a frame as seen by the receiver
    sequence s_first_data;
        take && pair_kind == `KIND_DATA && last_q == `KIND_SSD;
    endsequence
    sequence s_take_esd2;
        take && pair_kind == `KIND_ESD2;
    endsequence
    sequence s_take_esd3;
        take && (pair_kind == `KIND_ESD3 || pair_kind == `KIND_ERR_ESD3);
    endsequence

    property p_ssd_zero;
        pair_valid && pair_kind == `KIND_SSD |-> pair_a == `TERN_ZERO && pair_b == `TERN_ZERO;
    endproperty
    a_ssd_zero: assert property (p_ssd_zero) else $error("start pair not zero");

    property p_ssd_count;
        s_first_data |-> ssd_cnt_q == 3'h3;
    endproperty
    a_ssd_count: assert property (p_ssd_count) else $error("start pair count wrong");

    property p_esd_clean;
        pair_valid && pair_kind == `KIND_ESD3 |-> pair_a == `TERN_POS && pair_b == `TERN_POS;
    endproperty
    a_esd_clean: assert property (p_esd_clean) else $error("clean end pair wrong");

    property p_esd_err;
        pair_valid && pair_kind == `KIND_ERR_ESD3 |-> pair_a == `TERN_NEG && pair_b == `TERN_NEG;
    endproperty
    a_esd_err: assert property (p_esd_err) else $error("error end pair wrong");

    property p_esd_zero;
        pair_valid && (pair_kind == `KIND_ESD1 || pair_kind == `KIND_ERR_ESD1
            || pair_kind == `KIND_ESD2) |-> pair_a == `TERN_ZERO && pair_b == `TERN_ZERO;
    endproperty
    a_esd_zero: assert property (p_esd_zero) else $error("end pair not zero");

    property p_esd2_order;
        s_take_esd2 |-> last_q == `KIND_ESD1 || last_q == `KIND_ERR_ESD1;
    endproperty
    a_esd2_order: assert property (p_esd2_order) else $error("second end pair misplaced");

    property p_esd3_order;
        s_take_esd3 |-> last_q == `KIND_ESD2;
    endproperty
    a_esd3_order: assert property (p_esd3_order) else $error("third end pair misplaced");

    property p_hold;
        pair_valid && !take |=> pair_valid && $stable(pair_a) && $stable(pair_b)
            && $stable(pair_kind);
    endproperty
    a_hold: assert property (p_hold) else $error("pair dropped while stalled");

    property p_flag_clear;
        $fell(tx_err_flag) |-> (pair_valid && pair_kind == `KIND_ERR_ESD1)
            || $past(pair_valid && pair_kind == `KIND_ERR_ESD1);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("error flag cleared early");

    property p_flag_esd;
        tx_err_flag |-> !(pair_valid && pair_kind == `KIND_ESD1);
    endproperty
    a_flag_esd: assert property (p_flag_esd) else $error("clean end with error flag");

    // The flag is only raised while data groups are being produced
    property p_flag_rise;
        $rose(tx_err_flag) |-> pair_valid && pair_kind == `KIND_DATA;
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("error flag set outside data");
endmodule

bind pcs_tx_stuff_and_error pcs_tx_sva u_sva (
    .ref_clk, .rst, .clk_en, .tx_en, .tx_er, .txd, .mii_ready,
    .pair_a, .pair_b, .pair_kind, .pair_valid, .pair_ready, .tx_err_flag
);
`default_nettype wire

//--- bench/mii_mac_model.sv
// Behavioural MAC driving the MII transmit side
`timescale 1ns/100ps
`default_nettype none

module mii_mac_model (
    // Clock and flow control
    input  wire logic       ref_clk,
    input  wire logic       clk_en,
    input  wire logic       mii_ready,
    // MII transmit
    output var  logic       tx_en,
    output var  logic       tx_er,
    output var  logic [3:0] txd
);
    // Quiet line at time zero
    initial begin
        tx_en = 1'b0;
        tx_er = 1'b0;
        txd   = 4'h0;
    end

    // One packet of {error, nibble}; each nibble is held until taken
    task automatic send(input logic [4:0] pk[$], input logic er_idle);
        int i;
        i = 0;
        tx_er <= er_idle;
        txd   <= ~txd;
        @(posedge ref_clk);
        while (i < pk.size()) begin
            tx_en <= 1'b1;
            tx_er <= pk[i][4];
            txd   <= pk[i][3:0];
            @(posedge ref_clk);
            if (clk_en && mii_ready) begin
                i++;
            end
        end
        tx_en <= 1'b0;
        tx_er <= er_idle;
        // Released data keeps toggling so the last nibble is not seen again
        repeat (3) begin
            txd <= ~txd;
            @(posedge ref_clk);
        end
        tx_er <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- bench/test_pcs_tx_stuff_and_error.sv
// Testbench for the transmit stuffing and end-delimiter block
`timescale 1ns/100ps
`default_nettype none
`include "pcs_tx_regs.vh"

module test_pcs_tx_stuff_and_error;
    logic       ref_clk;
    logic       rst;
    logic       clk_en;
    logic       pair_ready;
    logic       flag_seen;
    wire        tx_en;
    wire        tx_er;
    wire  [3:0] txd;
    wire        mii_ready;
    wire  [1:0] pair_a;
    wire  [1:0] pair_b;
    wire  [2:0] pair_kind;
    wire        pair_valid;
    wire        tx_err_flag;
    int         mismatches;
    int         total_checks;
    logic [8:0] got_q[$];

    pcs_tx_stuff_and_error u_dut (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .tx_en(tx_en), .tx_er(tx_er),
        .txd(txd), .mii_ready(mii_ready), .pair_a(pair_a), .pair_b(pair_b),
        .pair_kind(pair_kind), .pair_valid(pair_valid), .pair_ready(pair_ready),
        .tx_err_flag(tx_err_flag)
    );

    mii_mac_model u_mac (
        .ref_clk(ref_clk), .clk_en(clk_en), .mii_ready(mii_ready),
        .tx_en(tx_en), .tx_er(tx_er), .txd(txd)
    );

    // Clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // Random stalls on the enable and the receiver
    always @(posedge ref_clk) begin
        clk_en     <= ($urandom % 8) != 0;
        pair_ready <= ($urandom % 4) != 0;
    end

    // Collect every pair handed over, note the error flag
    always @(posedge ref_clk) begin
        if (!rst && clk_en && pair_valid && pair_ready) begin
            got_q.push_back({2'h0, pair_kind, pair_a, pair_b});
        end
        if (tx_err_flag === 1'b1) begin
            flag_seen <= 1'b1;
        end
    end

    function automatic logic [1:0] t3(input int v);
        return (v == 0) ? `TERN_NEG : (v == 1) ? `TERN_ZERO : `TERN_POS;
    endfunction

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Mode 0 random clean, 1 error first, 2 error last only, 3 error outside
    task automatic run_pkt(input string name, input int n, input int mode);
        logic [4:0] pk[$];
        logic [8:0] exp_q[$];
        int         bits[$];
        int         g;
        int         k;
        int         j;
        int         ngrp;
        for (k = 0; k < n; k++) begin
            g = (mode == 0) ? $urandom % 16 : (mode == 2 && k == n - 1) ? 0 : 5;
            pk.push_back({1'((mode == 1 && k == 0) || (mode == 2 && k == n - 1)), 4'(g)});
            for (j = 0; j < 4; j++) begin
                bits.push_back((g >> j) & 1);
            end
        end
        while (bits.size() % 3 != 0) begin
            bits.push_back(0);
        end
        for (k = 0; k < 3; k++) begin
            exp_q.push_back({2'h0, `KIND_SSD, `TERN_ZERO, `TERN_ZERO});
        end
        for (k = 0; k < bits.size(); k += 3) begin
            g = bits[k] + 2 * bits[k + 1] + 4 * bits[k + 2];
            g = (g > 3) ? g + 1 : g;
            exp_q.push_back({2'h0, `KIND_DATA, t3(g / 3), t3(g % 3)});
        end
        g = (mode == 1) ? `KIND_ERR_ESD1 : `KIND_ESD1;
        exp_q.push_back({2'h0, 3'(g), `TERN_ZERO, `TERN_ZERO});
        exp_q.push_back({2'h0, `KIND_ESD2, `TERN_ZERO, `TERN_ZERO});
        if (mode == 1 || mode == 2) begin
            exp_q.push_back({2'h0, `KIND_ERR_ESD3, `TERN_NEG, `TERN_NEG});
        end else begin
            exp_q.push_back({2'h0, `KIND_ESD3, `TERN_POS, `TERN_POS});
        end
        got_q.delete();
        flag_seen = 1'b0;
        u_mac.send(pk, mode == 3);
        for (k = 0; k < 3000 && got_q.size() < exp_q.size(); k++) begin
            @(posedge ref_clk);
        end
        repeat (10) @(posedge ref_clk);
        check("pair_count", 9'(got_q.size()), 9'(exp_q.size()));
        ngrp = 0;
        for (k = 0; k < exp_q.size() && k < got_q.size(); k++) begin
            check("pair", got_q[k], exp_q[k]);
            ngrp += (got_q[k][6:4] == `KIND_DATA);
        end
        if (mode == 0 && n % 6 == 0) check("stuff_bits", 9'(3 * ngrp - 4 * n), 9'h0);
        if (mode == 0 && n % 6 == 2) check("stuff_bits", 9'(3 * ngrp - 4 * n), 9'h1);
        if (mode == 0 && n % 6 == 4) check("stuff_bits", 9'(3 * ngrp - 4 * n), 9'h2);
        check("err_flag_seen", {8'h0, flag_seen}, 9'(mode == 1));
        if (mode == 3) check("err_idle_flag", {8'h0, flag_seen}, 9'h0);
        // Closing pairs checked on their own so the error forms are reported by name
        if (got_q.size() >= 3) begin
            check("end_pair1", got_q[got_q.size() - 3], exp_q[exp_q.size() - 3]);
            check("end_pair3", got_q[got_q.size() - 1], exp_q[exp_q.size() - 1]);
        end
        check("err_flag_end", {8'h0, tx_err_flag}, 9'h0);
        $display("test %s done", name);
    endtask

    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run length
    initial begin
        #(200000);
        mismatches++;
        report_and_stop();
    end

    // Main sequence: frame lengths 64 to 67 bytes plus preamble, then error cases
    initial begin
        rst = 1'b1;
        clk_en = 1'b0;
        pair_ready = 1'b0;
        flag_seen = 1'b0;
        mismatches = 0;
        total_checks = 0;
        void'($urandom(32'h1A0B));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        run_pkt("len64", 144, 0);
        run_pkt("len65", 146, 0);
        run_pkt("len66", 148, 0);
        run_pkt("len67", 150, 0);
        run_pkt("err_first", 6, 1);
        run_pkt("err_last", 8, 2);
        run_pkt("err_idle", 6, 3);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        run_pkt("after_reset", 146, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
